// ---- shared/cipr_cfg.svh ----
`ifndef CIPR_CFG_SVH
`define CIPR_CFG_SVH

// ---------------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------------
`define CIPR_IDX_PIN        16'h1002
`define CIPR_IDX_PWR        16'h1003
`define CIPR_IDX_RSM        16'h2000
`define CIPR_IDX_STAT       16'h2001
`define CIPR_ADDR_PIN       16'h4008
`define CIPR_ADDR_PWR       16'h400C
`define CIPR_ADDR_RSM       16'h8000
`define CIPR_ADDR_STAT      16'h8004

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CIPR_PIN_RST        8'h00
`define CIPR_PWR_RST        8'h00
`define CIPR_RSM_RST        8'h00

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define CIPR_PIN_OSC        7
`define CIPR_PIN_FMT_HI     6
`define CIPR_PIN_FMT_LO     5
`define CIPR_PIN_DIR_HI     4
`define CIPR_PIN_DIR_LO     1
`define CIPR_PIN_GP         0
`define CIPR_PWR_SUSP       7
`define CIPR_PWR_IRQ        6
`define CIPR_PWR_PLL        5
`define CIPR_PWR_DAC        4
`define CIPR_PWR_ADCL       3
`define CIPR_PWR_ADCR       2
`define CIPR_PWR_GAINL      1
`define CIPR_PWR_GAINR      0
`define CIPR_RSM_ROBUST     7
`define CIPR_RSM_FMT_HI     6
`define CIPR_RSM_FMT_LO     5
`define CIPR_RSM_INV        4
`define CIPR_RSM_WID_HI     3
`define CIPR_RSM_WID_LO     2
`define CIPR_RSM_STEREO     1
`define CIPR_RSM_RUN        0

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define CIPR_CLK_MHZ        200
`define CIPR_INIT_TIME_MS   20
`define CIPR_INIT_CYCLES    (`CIPR_INIT_TIME_MS * 1000 * `CIPR_CLK_MHZ)
`define CIPR_RESTART_CYCLES 2048
`define CIPR_CNT_W          22

`endif

// ---- shared/cipr_pkg.sv ----
package cipr_pkg;

    typedef enum logic [1:0] {
        CIPR_SER_FOUR_PIN,
        CIPR_SER_SIX_PIN,
        CIPR_SER_THREE_PIN_IN
    } cipr_ser_t;

    typedef enum logic [1:0] {
        CIPR_OUT_I2S,
        CIPR_OUT_LSB16,
        CIPR_OUT_LSB18,
        CIPR_OUT_LSB20
    } cipr_outfmt_t;

    typedef enum logic [1:0] {
        CIPR_WID_RESERVED,
        CIPR_WID_8,
        CIPR_WID_16,
        CIPR_WID_24
    } cipr_width_t;

    typedef struct packed {
        logic       gp_mode;
        logic [3:0] gp_dir_in;
        cipr_ser_t  ser_fmt;
    } cipr_pins_t;

    typedef struct packed {
        logic pll_off;
        logic dac_off;
        logic adc_l_off;
        logic adc_r_off;
        logic gain_l_off;
        logic gain_r_off;
    } cipr_power_t;

    typedef struct packed {
        logic         robust_wclk;
        cipr_outfmt_t out_fmt;
        logic         mono_invert;
        cipr_width_t  width;
        logic         stereo;
        logic         run;
    } cipr_resamp_t;

    typedef enum {
        CIPR_ST_INIT,
        CIPR_ST_NORMAL,
        CIPR_ST_RESTART
    } cipr_state_t;

endpackage

// ---- logic/cipr_sync.sv ----
module cipr_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic d,
    output logic      q
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ---------------------------------------------------------------
    // Three stages; the level moves only when the last two agree
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= 1'b0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end

endmodule // cipr_sync

// ---- logic/cipr_regs.sv ----
`include "cipr_cfg.svh"

module cipr_regs #(
    parameter int INIT_CYCLES = `CIPR_INIT_CYCLES
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [15:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic                   usb_clk_on,
    input  wire logic                   usb_suspend,
    input  wire logic                   usb_irq_n,
    input  wire logic                   mcu_osc_request,
    output logic                        osc_enable,
    output logic                        mcu_suspend_input,
    output logic                        mcu_external_irq_n,
    output logic                        init_busy,
    output logic [3:0]                  shared_pin_oe,
    output cipr_pkg::cipr_pins_t        pins_cfg,
    output cipr_pkg::cipr_power_t       power_cfg,
    output cipr_pkg::cipr_resamp_t      resamp_cfg
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [7:0]                 pin_r;
    logic [7:0]                 pin_nxt;
    logic [7:0]                 pwr_r;
    logic [7:0]                 pwr_nxt;
    logic [7:0]                 rsm_r;
    logic [7:0]                 rsm_nxt;
    logic                       dp_write_r;
    logic [15:0]                dp_addr_r;
    logic                       aphase;
    logic                       wr_pin;
    logic                       wr_pwr;
    logic                       wr_rsm;
    logic [7:0]                 rd_val;
    logic [7:0]                 stat_val;
    cipr_pkg::cipr_state_t      state_r;
    logic [`CIPR_CNT_W-1:0]     cnt_r;
    logic                       clk_on_s;
    logic                       clk_on_d_r;
    logic                       clk_on_rise;
    logic                       clk_on_fall;
    logic                       restart_irq_r;
    logic                       restart_osc_r;
    logic                       init_done;
    cipr_pkg::cipr_pins_t       pins_nxt;
    cipr_pkg::cipr_power_t      power_nxt;
    cipr_pkg::cipr_resamp_t     resamp_nxt;

    // ---------------------------------------------------------------
    // Clock-on pin synchroniser
    // ---------------------------------------------------------------
    cipr_sync u_clk_on_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (usb_clk_on),
        .q       (clk_on_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_on_d_r <= 1'b0;
        end else begin
            clk_on_d_r <= clk_on_s;
        end
    end

    assign clk_on_rise = clk_on_s & ~clk_on_d_r;
    assign clk_on_fall = ~clk_on_s & clk_on_d_r;

    // ---------------------------------------------------------------
    // AHB-Lite address phase
    // ---------------------------------------------------------------
    assign aphase = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_r <= 1'b0;
            dp_addr_r  <= 16'h0000;
        end else if (hready) begin
            dp_write_r <= aphase & hwrite;
            dp_addr_r  <= haddr;
        end
    end

    // Writes during the initialisation window are dropped
    assign init_done = (state_r != cipr_pkg::CIPR_ST_INIT);
    assign wr_pin = dp_write_r & init_done
                    & (dp_addr_r == `CIPR_ADDR_PIN);
    assign wr_pwr = dp_write_r & init_done
                    & (dp_addr_r == `CIPR_ADDR_PWR);
    assign wr_rsm = dp_write_r & init_done
                    & (dp_addr_r == `CIPR_ADDR_RSM);

    // ---------------------------------------------------------------
    // Register next values
    // ---------------------------------------------------------------
    always_comb begin
        pin_nxt = pin_r;
        pwr_nxt = pwr_r;
        rsm_nxt = rsm_r;
        if (wr_pin) begin
            pin_nxt = hwdata[7:0];
        end
        if (wr_pwr) begin
            pwr_nxt = hwdata[7:0];
        end
        if (wr_rsm) begin
            rsm_nxt = hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_r <= `CIPR_PIN_RST;
            pwr_r <= `CIPR_PWR_RST;
            rsm_r <= `CIPR_RSM_RST;
        end else begin
            pin_r <= pin_nxt;
            pwr_r <= pwr_nxt;
            rsm_r <= rsm_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Read data, with bypass of a write still in its data phase
    // ---------------------------------------------------------------
    assign stat_val = {3'b000, restart_irq_r, clk_on_s, osc_enable,
                       (state_r == cipr_pkg::CIPR_ST_RESTART),
                       init_done};

    always_comb begin
        case (haddr)
            `CIPR_ADDR_PIN:  rd_val = pin_nxt;
            `CIPR_ADDR_PWR:  rd_val = pwr_nxt;
            `CIPR_ADDR_RSM:  rd_val = rsm_nxt;
            `CIPR_ADDR_STAT: rd_val = stat_val;
            default:         rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (aphase && !hwrite) begin
            hrdata <= {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Initialisation window and restart sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= cipr_pkg::CIPR_ST_INIT;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                cipr_pkg::CIPR_ST_INIT: begin
                    if (cnt_r == `CIPR_CNT_W'(INIT_CYCLES - 1)) begin
                        state_r <= cipr_pkg::CIPR_ST_NORMAL;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                cipr_pkg::CIPR_ST_NORMAL: begin
                    if (clk_on_rise) begin
                        state_r <= cipr_pkg::CIPR_ST_RESTART;
                        cnt_r   <= '0;
                    end
                end
                cipr_pkg::CIPR_ST_RESTART: begin
                    if (clk_on_fall) begin
                        state_r <= cipr_pkg::CIPR_ST_NORMAL;
                        cnt_r   <= '0;
                    end else if (cnt_r ==
                            `CIPR_CNT_W'(`CIPR_RESTART_CYCLES - 1)) begin
                        state_r <= cipr_pkg::CIPR_ST_NORMAL;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r <= cipr_pkg::CIPR_ST_INIT;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // Restart irq rises when the count ends, drops with clock-on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_irq_r <= 1'b0;
        end else if (clk_on_fall) begin
            restart_irq_r <= 1'b0;
        end else if (state_r == cipr_pkg::CIPR_ST_RESTART && cnt_r ==
                     `CIPR_CNT_W'(`CIPR_RESTART_CYCLES - 1)) begin
            restart_irq_r <= 1'b1;
        end
    end

    // Oscillator forced on from clock-on rise until clock-on falls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_osc_r <= 1'b0;
        end else if (clk_on_fall) begin
            restart_osc_r <= 1'b0;
        end else if (clk_on_rise) begin
            restart_osc_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Field decode
    // ---------------------------------------------------------------
    always_comb begin
        pins_nxt.gp_mode   = pin_nxt[`CIPR_PIN_GP];
        pins_nxt.gp_dir_in =
            pin_nxt[`CIPR_PIN_DIR_HI:`CIPR_PIN_DIR_LO];
        case (pin_nxt[`CIPR_PIN_FMT_HI:`CIPR_PIN_FMT_LO])
            2'b00:   pins_nxt.ser_fmt = cipr_pkg::CIPR_SER_FOUR_PIN;
            2'b01:   pins_nxt.ser_fmt = cipr_pkg::CIPR_SER_SIX_PIN;
            default: pins_nxt.ser_fmt = cipr_pkg::CIPR_SER_THREE_PIN_IN;
        endcase
    end

    always_comb begin
        power_nxt.pll_off    = pwr_nxt[`CIPR_PWR_PLL];
        power_nxt.dac_off    = pwr_nxt[`CIPR_PWR_DAC];
        power_nxt.adc_l_off  = pwr_nxt[`CIPR_PWR_ADCL];
        power_nxt.adc_r_off  = pwr_nxt[`CIPR_PWR_ADCR];
        power_nxt.gain_l_off = pwr_nxt[`CIPR_PWR_GAINL];
        power_nxt.gain_r_off = pwr_nxt[`CIPR_PWR_GAINR];
    end

    always_comb begin
        resamp_nxt.robust_wclk = rsm_nxt[`CIPR_RSM_ROBUST];
        resamp_nxt.out_fmt     = cipr_pkg::cipr_outfmt_t'(
            rsm_nxt[`CIPR_RSM_FMT_HI:`CIPR_RSM_FMT_LO]);
        resamp_nxt.mono_invert = rsm_nxt[`CIPR_RSM_INV];
        resamp_nxt.width       = cipr_pkg::cipr_width_t'(
            rsm_nxt[`CIPR_RSM_WID_HI:`CIPR_RSM_WID_LO]);
        resamp_nxt.stereo      = rsm_nxt[`CIPR_RSM_STEREO];
        resamp_nxt.run         = rsm_nxt[`CIPR_RSM_RUN];
    end

    // ---------------------------------------------------------------
    // Configuration outputs
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_cfg      <= '0;
            power_cfg     <= '0;
            resamp_cfg    <= '0;
            shared_pin_oe <= 4'h0;
        end else begin
            pins_cfg      <= pins_nxt;
            power_cfg     <= power_nxt;
            resamp_cfg    <= resamp_nxt;
            shared_pin_oe <= pins_nxt.gp_mode ?
                             ~pins_nxt.gp_dir_in : 4'h0;
        end
    end

    // ---------------------------------------------------------------
    // Oscillator, suspend and interrupt routing
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_enable <= 1'b1;
        end else if (!pin_nxt[`CIPR_PIN_OSC]) begin
            osc_enable <= 1'b1;
        end else begin
            osc_enable <= mcu_osc_request | restart_osc_r
                          | clk_on_rise;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcu_suspend_input  <= 1'b0;
            mcu_external_irq_n <= 1'b1;
        end else begin
            mcu_suspend_input  <= pwr_nxt[`CIPR_PWR_SUSP] ?
                                  clk_on_s : usb_suspend;
            mcu_external_irq_n <= pwr_nxt[`CIPR_PWR_IRQ] ?
                                  restart_irq_r : usb_irq_n;
        end
    end

    // Tells the far side to keep D+ low while the window runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_busy <= 1'b1;
        end else if (state_r == cipr_pkg::CIPR_ST_INIT &&
                     cnt_r == `CIPR_CNT_W'(INIT_CYCLES - 1)) begin
            init_busy <= 1'b0;
        end
    end

endmodule // cipr_regs

// ---- bench/cipr_regs_monitor.sv ----
`include "cipr_cfg.svh"

module cipr_regs_monitor #(
    parameter int INIT_CYCLES = 100
) (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [15:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire logic                  usb_clk_on,
    input wire logic                  osc_enable,
    input wire logic                  init_busy,
    input wire logic [3:0]            shared_pin_oe,
    input wire cipr_pkg::cipr_pins_t  pins_cfg,
    input wire cipr_pkg::cipr_power_t power_cfg,
    input wire cipr_pkg::cipr_resamp_t resamp_cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        wr_q;
    logic [15:0] a_q;
    int          icnt;

    // ---------------------------------------------------------------
    // Data phase tracking and init window length
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            a_q  <= 16'h0000;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite;
            a_q  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            icnt <= 0;
        end else if (init_busy) begin
            icnt <= icnt + 1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_BUS: assert property (hreadyout && !hresp && hrdata[31:8] == '0)
        else $error("bus answer not zero wait OKAY");
    AST_GP_OE: assert property (pins_cfg.gp_mode |->
        shared_pin_oe == ~pins_cfg.gp_dir_in)
        else $error("pin output enables wrong");
    AST_SER: assert property (pins_cfg.ser_fmt != 2'b11)
        else $error("pin format code out of range");
    AST_INIT_CFG: assert property (init_busy |->
        {pins_cfg, power_cfg, resamp_cfg} == '0)
        else $error("config changed during init window");
    AST_INIT_LEN: assert property (init_busy |-> icnt <= INIT_CYCLES + 1)
        else $error("init window too long");
    AST_INIT_END: assert property ($fell(init_busy) |->
        icnt >= INIT_CYCLES - 1)
        else $error("init window too short");
    AST_PWR_WR: assert property (wr_q && hready && !init_busy &&
        a_q == `CIPR_ADDR_PWR |=> power_cfg == $past(hwdata[5:0]))
        else $error("power write not applied");
    AST_RSM_WR: assert property (wr_q && hready && !init_busy &&
        a_q == `CIPR_ADDR_RSM |=> resamp_cfg == $past(hwdata[7:0]))
        else $error("resampler write not applied");
    AST_PIN_WR: assert property (wr_q && hready && !init_busy &&
        a_q == `CIPR_ADDR_PIN |=> {pins_cfg.gp_dir_in, pins_cfg.gp_mode}
        == $past(hwdata[4:0]))
        else $error("pin write not applied");
    AST_OSC_WAKE: assert property ($rose(usb_clk_on) |-> ##[1:8] osc_enable)
        else $error("oscillator not enabled on wake");
endmodule // cipr_regs_monitor

// ---- bench/cipr_usb_model.sv ----
module cipr_usb_model (
    input  wire logic hclk,
    input  wire logic init_busy,
    input  wire logic cmd_clk_on,
    input  wire logic cmd_suspend,
    input  wire logic cmd_irq_n,
    input  wire logic cmd_osc,
    output logic      usb_clk_on = 1'b0,
    output logic      usb_suspend = 1'b0,
    output logic      usb_irq_n = 1'b1,
    output logic      mcu_osc_request = 1'b0,
    output logic      dp_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // Far side levels change only just after a clock edge
    always @(posedge hclk) begin
        usb_clk_on      <= cmd_clk_on;
        usb_suspend     <= cmd_suspend;
        usb_irq_n       <= cmd_irq_n;
        mcu_osc_request <= cmd_osc;
    end

    // No connect indication while registers initialise
    assign dp_low = init_busy;
endmodule // cipr_usb_model

// ---- bench/tb_top.sv ----
`include "cipr_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_CYCLES = 100;
    logic                   hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic                   hwrite = 1'b0, hreadyout, hresp, dp_low;
    logic [1:0]             htrans = 2'b00;
    logic [2:0]             hsize = 3'b010;
    logic [15:0]            haddr = 16'h0000;
    logic [31:0]            hwdata = 32'h0000_0000, hrdata, rd;
    logic                   c_clk = 1'b0, c_susp = 1'b0, c_irq = 1'b1;
    logic                   c_osc = 1'b0, clk_on, susp, irq_n, osc_req;
    logic                   osc_en, m_susp, m_irq_n, init_busy;
    logic [3:0]             oe;
    logic [7:0]             v;
    cipr_pkg::cipr_pins_t   pins;
    cipr_pkg::cipr_power_t  pwr;
    cipr_pkg::cipr_resamp_t rsm;
    int                     errors = 0, checked = 0, cyc = 0, t0, n;

    cipr_regs #(.INIT_CYCLES(INIT_CYCLES)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .usb_clk_on(clk_on), .usb_suspend(susp),
        .usb_irq_n(irq_n), .mcu_osc_request(osc_req), .osc_enable(osc_en),
        .mcu_suspend_input(m_susp), .mcu_external_irq_n(m_irq_n),
        .init_busy(init_busy), .shared_pin_oe(oe), .pins_cfg(pins),
        .power_cfg(pwr), .resamp_cfg(rsm));

    cipr_usb_model u_usb (
        .hclk(hclk), .init_busy(init_busy), .cmd_clk_on(c_clk),
        .cmd_suspend(c_susp), .cmd_irq_n(c_irq), .cmd_osc(c_osc),
        .usb_clk_on(clk_on), .usb_suspend(susp), .usb_irq_n(irq_n),
        .mcu_osc_request(osc_req), .dp_low(dp_low));

    // ---------------------------------------------------------------
    // Clock, cycle count and bus tasks
    // ---------------------------------------------------------------
    initial begin
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) cyc <= cyc + 1;

    task automatic results();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask

    // Address phase held until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int k;
        k = 0;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        rd = hrdata;
        if (k >= 100) begin
            errors++;
            results();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ahb(1'b1, a, d);
        tick(1);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        ahb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, e});
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        tick(4);
        hresetn <= 1'b1;
        t0 = cyc;
        chk(init_busy, 1);
        chk(dp_low, 1);
        wr(`CIPR_ADDR_PWR, 8'h3F);
        rdchk(`CIPR_ADDR_PWR, 8'h00);
        rdchk(`CIPR_ADDR_PIN, 8'h00);
        rdchk(`CIPR_ADDR_RSM, 8'h00);
        for (n = 0; n < 300 && init_busy !== 1'b0; n++) tick(1);
        chk(cyc - t0 >= INIT_CYCLES && cyc - t0 <= INIT_CYCLES + 3, 1);
        if (n >= 300) results();
        chk(dp_low, 0);
        rdchk(`CIPR_ADDR_STAT, 8'h05);
        wr(16'h8008, 8'hFF);
        rdchk(16'h8008, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(`CIPR_ADDR_PIN, 8'(k << 5));
            chk(pins.ser_fmt, (k > 1) ? 2 : k);
            rdchk(`CIPR_ADDR_PIN, 8'(k << 5));
        end
        wr(`CIPR_ADDR_PIN, 8'h0B);
        chk(oe, 4'hA);
        for (int k = 0; k < 4; k++) begin
            v = {k[0], k[1:0], k[1], k[1:0], k[0], ~k[0]};
            wr(`CIPR_ADDR_RSM, v);
            chk(rsm, v);
            rdchk(`CIPR_ADDR_RSM, v);
        end
        wr(`CIPR_ADDR_PWR, 8'h2A);
        chk(pwr, 6'h2A);
        wr(`CIPR_ADDR_PWR, 8'h15);
        chk(pwr, 6'h15);
        rdchk(`CIPR_ADDR_PWR, 8'h15);
        c_susp <= 1'b1;
        c_irq  <= 1'b0;
        tick(3);
        chk(m_susp, 1);
        chk(m_irq_n, 0);
        c_irq <= 1'b1;
        wr(`CIPR_ADDR_PWR, 8'h80);
        tick(1);
        chk(m_susp, 0);
        chk(m_irq_n, 1);
        chk(osc_en, 1);
        wr(`CIPR_ADDR_PIN, 8'h80);
        tick(1);
        chk(osc_en, 0);
        c_osc <= 1'b1;
        tick(3);
        chk(osc_en, 1);
        c_osc <= 1'b0;
        wr(`CIPR_ADDR_PWR, 8'hC0);
        tick(2);
        chk(m_irq_n, 0);
        c_clk <= 1'b1;
        t0 = cyc;
        tick(10);
        chk(osc_en, 1);
        chk(m_susp, 1);
        for (n = 0; n < 3000 && m_irq_n !== 1'b1; n++) tick(1);
        chk(cyc - t0 >= 2048 && cyc - t0 <= 2062, 1);
        rdchk(`CIPR_ADDR_STAT, 8'h1D);
        c_clk <= 1'b0;
        tick(8);
        chk(m_irq_n, 0);
        chk(osc_en, 0);
        results();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        results();
    end
endmodule // tb_top

bind cipr_regs cipr_regs_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .usb_clk_on(usb_clk_on), .osc_enable(osc_enable),
    .init_busy(init_busy), .shared_pin_oe(shared_pin_oe),
    .pins_cfg(pins_cfg), .power_cfg(power_cfg), .resamp_cfg(resamp_cfg));
